// [hw/pdw_pkg.sv]
// package: constants for the power-down and pin resume block
package pdw_pkg;

  // ---------------------------------------------------------------
  // mode selector values for second-port special accesses
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_PEND = 4'h9;
  localparam logic [3:0] MODE_EDGE = 4'hA;
  localparam logic [3:0] MODE_EN = 4'hB;
  localparam logic [3:0] MODE_DIR = 4'hF;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] EN_RST = 8'hFF;
  localparam logic [7:0] EDGE_RST = 8'hFF;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] PEND_RST = 8'h00;
  localparam logic [10:0] PC_WAKE = 11'h7FF;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_NS = 32'h0000_0004;
  localparam int unsigned NS_PER_US = 32'h0000_03E8;
  localparam int unsigned TIMEOUT_US = 32'h0000_3E80;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * NS_PER_US / CLK_NS;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic {
    ST_RUN = 1'b0,
    ST_HALT = 1'b1
  } pdw_state_type;

endpackage

// [hw/pdw_edge_if.sv]
// interface: edge select in, qualified edge hits out
`timescale 1ns/100ps
interface pdw_edge_if;
  logic [7:0] edge_sel;
  logic [7:0] hits;
  modport det (input edge_sel, output hits);
  modport use_side (output edge_sel, input hits);
endinterface

// [hw/pdw_edge.sv]
// module: second-port pin synchroniser and selected edge detector
`timescale 1ns/100ps
module pdw_edge (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic [7:0] pins,
  // edge select and hits
  pdw_edge_if.det e
);
  logic [7:0] sync1_q;
  logic [7:0] sync1_d;
  logic [7:0] sync2_q;
  logic [7:0] sync2_d;
  logic [7:0] prev_q;
  logic [7:0] prev_d;

  // ---------------------------------------------------------------
  // sample registers
  // ---------------------------------------------------------------
  always_comb begin
    sync1_d = pins;
    sync2_d = sync1_q;
    prev_d = sync2_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      prev_q <= 8'h00;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
    end
  end

  // ---------------------------------------------------------------
  // per-pin edge choice
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      // 1 picks falling, 0 picks rising
      assign e.hits[i] = e.edge_sel[i] ? (prev_q[i] & ~sync2_q[i])
                                       : (~prev_q[i] & sync2_q[i]);
    end
  endgenerate

endmodule

// [hw/pdw_top.sv]
// module: power-down control with multi-input pin resume
`timescale 1ns/100ps
//
// Contract
// - halt instruction enters power-down and stops the core clock
// - while powered down only the supervisor timer keeps running
// - halt with timer enabled clears timer, sets expiry, clears halted
// - leave power-down only on timer overflow, enabled pin edge, reset pin
// - resume enable bits are active low; set bit masks its pin
// - edge select bit 1 picks falling edge, 0 picks rising edge
// - reset loads resume enable and edge select with all ones
// - selected edge latches a one in pending until software clears it
// - pin wakeup loads program counter with top address, like reset
// - pending register needs no defined value after reset
// - port write with pending selected swaps accumulator and pending
// - mode 09h pending, 0Ah edge, 0Bh enable, 0Fh direction
// - same edge and pending logic gives run interrupt and wakeup
// - supervisor timer timeout clears the expiry flag
//
module pdw_top #(
  parameter int unsigned TIMER_CYCLES = pdw_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic EXTERNAL_RESET_PIN_N,
  // core instruction strobes
  input wire logic HALT_EXEC,
  input wire logic TIMER_CLEAR,
  input wire logic TIMER_ENABLE,
  // second-port exchange
  input wire logic PORT_WR,
  input wire logic [3:0] MODE_VALUE,
  input wire logic [7:0] ACC_IN,
  output logic [7:0] ACC_OUT,
  output logic ACC_OUT_VALID,
  output logic [7:0] PORT_DIR,
  output logic [7:0] PORT_DATA,
  // pins
  input wire logic [7:0] SECOND_PORT_PINS,
  // power and status
  output logic CORE_CLK_EN,
  output logic EXPIRY_FLAG,
  output logic HALTED_FLAG,
  output logic PC_LOAD,
  output logic TIMER_RESET,
  output logic PIN_IRQ,
  output logic [7:0] RESUME_PENDING
);
  pdw_edge_if e ();
  pdw_pkg::pdw_state_type state_q, state_d;
  logic [7:0] en_n_q, en_n_d, edge_q, edge_d, pend_q, pend_d;
  logic [7:0] dir_q, dir_d, data_q, data_d, acc_q, acc_d;
  logic [31:0] cnt_q, cnt_d;
  logic expiry_q, expiry_d, halted_q, halted_d, run_q, run_d;
  logic accv_q, accv_d, pcl_q, pcl_d, trst_q, trst_d, irq_q, irq_d;
  logic [7:0] en_hit;
  logic ovf, rext, run, halt_req, swap, wake;

  pdw_edge u_edge (
    .clk(CORE_CLK),
    .rst(RST),
    .pins(SECOND_PORT_PINS),
    .e(e.det)
  );

  // ---------------------------------------------------------------
  // events
  // ---------------------------------------------------------------
  assign e.edge_sel = edge_q;
  assign en_hit = e.hits & ~en_n_q;
  assign rext = ~EXTERNAL_RESET_PIN_N;
  assign run = (state_q == pdw_pkg::ST_RUN);
  assign halt_req = run & HALT_EXEC;
  assign swap = run & PORT_WR & (MODE_VALUE == pdw_pkg::MODE_PEND);
  assign ovf = TIMER_ENABLE & (cnt_q == TIMER_CYCLES - 1);
  assign wake = ~run & ((|en_hit) | ovf | rext);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      pdw_pkg::ST_RUN: begin
        if (HALT_EXEC && !rext) begin
          state_d = pdw_pkg::ST_HALT;
        end
      end
      pdw_pkg::ST_HALT: begin
        if (wake) begin
          state_d = pdw_pkg::ST_RUN;
        end
      end
      default: state_d = pdw_pkg::ST_RUN;
    endcase
    run_d = (state_d == pdw_pkg::ST_RUN);
    // timer alone keeps counting while halted
    if (rext || halt_req || (run && TIMER_CLEAR) || !TIMER_ENABLE) begin
      cnt_d = 32'h0000_0000;
    end else if (ovf) begin
      cnt_d = 32'h0000_0000;
    end else begin
      cnt_d = cnt_q + 32'h0000_0001;
    end
    expiry_d = expiry_q;
    halted_d = halted_q;
    if (ovf) begin
      expiry_d = 1'b0;
    end else if (halt_req && TIMER_ENABLE) begin
      expiry_d = 1'b1;
    end else if (run && TIMER_CLEAR) begin
      expiry_d = 1'b1;
    end
    if (halt_req) begin
      halted_d = 1'b0;
    end else if (run && TIMER_CLEAR) begin
      halted_d = 1'b1;
    end
    pcl_d = rext | ovf | (~run & (|en_hit));
    trst_d = ovf;
    irq_d = run & (|en_hit);
    // pending: set wins over software write
    pend_d = pend_q | e.hits;
    acc_d = acc_q;
    accv_d = 1'b0;
    en_n_d = en_n_q;
    edge_d = edge_q;
    dir_d = dir_q;
    data_d = data_q;
    if (rext) begin
      en_n_d = pdw_pkg::EN_RST;
      edge_d = pdw_pkg::EDGE_RST;
      dir_d = pdw_pkg::DIR_RST;
    end else if (run && PORT_WR) begin
      if (swap) begin
        pend_d = ACC_IN | e.hits;
        acc_d = pend_q;
        accv_d = 1'b1;
      end else if (MODE_VALUE == pdw_pkg::MODE_EDGE) begin
        edge_d = ACC_IN;
      end else if (MODE_VALUE == pdw_pkg::MODE_EN) begin
        en_n_d = ACC_IN;
      end else if (MODE_VALUE == pdw_pkg::MODE_DIR) begin
        dir_d = ACC_IN;
      end else begin
        data_d = ACC_IN;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_q <= pdw_pkg::ST_RUN;
      run_q <= 1'b1;
      cnt_q <= 32'h0000_0000;
      expiry_q <= 1'b1;
      halted_q <= 1'b1;
      pcl_q <= 1'b0;
      trst_q <= 1'b0;
      irq_q <= 1'b0;
      pend_q <= pdw_pkg::PEND_RST;
      acc_q <= 8'h00;
      accv_q <= 1'b0;
      en_n_q <= pdw_pkg::EN_RST;
      edge_q <= pdw_pkg::EDGE_RST;
      dir_q <= pdw_pkg::DIR_RST;
      data_q <= pdw_pkg::DATA_RST;
    end else begin
      state_q <= state_d;
      run_q <= run_d;
      cnt_q <= cnt_d;
      expiry_q <= expiry_d;
      halted_q <= halted_d;
      pcl_q <= pcl_d;
      trst_q <= trst_d;
      irq_q <= irq_d;
      pend_q <= pend_d;
      acc_q <= acc_d;
      accv_q <= accv_d;
      en_n_q <= en_n_d;
      edge_q <= edge_d;
      dir_q <= dir_d;
      data_q <= data_d;
    end
  end

  assign CORE_CLK_EN = run_q;
  assign EXPIRY_FLAG = expiry_q;
  assign HALTED_FLAG = halted_q;
  assign PC_LOAD = pcl_q;
  assign TIMER_RESET = trst_q;
  assign PIN_IRQ = irq_q;
  assign RESUME_PENDING = pend_q;
  assign ACC_OUT = acc_q;
  assign ACC_OUT_VALID = accv_q;
  assign PORT_DIR = dir_q;
  assign PORT_DATA = data_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_halt;
    halt_req && !rext;
  endsequence
  sequence s_pin_wake;
    !run && (|en_hit) && !ovf && !rext;
  endsequence

  property p_halt_stop;
    @(posedge CORE_CLK) disable iff (RST)
    s_halt |=> !CORE_CLK_EN && !run;
  endproperty
  a_halt_stop: assert property (p_halt_stop)
    else $error("halt did not stop core clock");

  property p_frozen;
    @(posedge CORE_CLK) disable iff (RST)
    (!run && en_hit == 8'h00 && !ovf && !rext) |=> !CORE_CLK_EN;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("left power-down without a wake event");

  property p_halt_flags;
    @(posedge CORE_CLK) disable iff (RST)
    (s_halt ##0 (TIMER_ENABLE && !ovf)) |=> EXPIRY_FLAG && !HALTED_FLAG
      && cnt_q == 32'h0000_0000;
  endproperty
  a_halt_flags: assert property (p_halt_flags)
    else $error("halt flags or timer wrong");

  property p_pin_wake;
    @(posedge CORE_CLK) disable iff (RST)
    s_pin_wake |=> CORE_CLK_EN && PC_LOAD && !TIMER_RESET;
  endproperty
  a_pin_wake: assert property (p_pin_wake)
    else $error("pin wake did not resume with pc load");

  property p_mask;
    @(posedge CORE_CLK) disable iff (RST)
    (!run && e.hits != 8'h00 && en_hit == 8'h00 && !ovf && !rext)
      |=> !CORE_CLK_EN && !PC_LOAD;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked pin woke the device");

  property p_reset_vals;
    @(posedge CORE_CLK) disable iff (RST)
    $past(RST) |-> en_n_q == pdw_pkg::EN_RST && edge_q == pdw_pkg::EDGE_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("enable or edge not all ones after reset");

  property p_sticky;
    @(posedge CORE_CLK) disable iff (RST)
    (!swap) |=> ((RESUME_PENDING & $past(pend_q)) == $past(pend_q))
      && ((RESUME_PENDING & $past(e.hits)) == $past(e.hits));
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("pending bit lost");

  property p_swap;
    @(posedge CORE_CLK) disable iff (RST)
    (swap && !rext) |=> ACC_OUT_VALID && ACC_OUT == $past(pend_q)
      && RESUME_PENDING == ($past(ACC_IN) | $past(e.hits))
      ##1 (!ACC_OUT_VALID || $past(swap));
  endproperty
  a_swap: assert property (p_swap)
    else $error("pending swap wrong");

  property p_route;
    @(posedge CORE_CLK) disable iff (RST)
    (run && PORT_WR && !rext && MODE_VALUE == pdw_pkg::MODE_EN)
      |=> en_n_q == $past(ACC_IN) && edge_q == $past(edge_q);
  endproperty
  a_route: assert property (p_route)
    else $error("enable write misrouted");

  property p_expiry_clr;
    @(posedge CORE_CLK) disable iff (RST)
    ovf |=> !EXPIRY_FLAG && TIMER_RESET && PC_LOAD;
  endproperty
  a_expiry_clr: assert property (p_expiry_clr)
    else $error("timeout did not clear expiry flag");

  property p_irq;
    @(posedge CORE_CLK) disable iff (RST)
    (run && (|en_hit)) |=> PIN_IRQ && (PC_LOAD == ($past(ovf) || $past(rext)));
  endproperty
  a_irq: assert property (p_irq)
    else $error("run-mode pin event gave no interrupt");

endmodule

// [tb/pdw_pin_model.sv]
// partner model: second-port pins and external reset source
`timescale 1ns/100ps
module pdw_pin_model (
  // clock
  input wire logic clk,
  // requests from the bench
  input wire logic [7:0] level_req,
  input wire logic reset_req,
  // lines seen by the device
  output logic [7:0] pins,
  output logic reset_pin_n
);
  // lines move just after the rising edge, one clock after the bench drives them
  always_ff @(posedge clk) begin
    pins <= level_req;
    reset_pin_n <= ~reset_req;
  end
endmodule

// [tb/tb.sv]
// testbench: power-down control with pin resume
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  num_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
`define WAITF(c) begin n = 0; \
  while ((c) !== 1'b1 && n < 60) begin @(negedge core_clk); n++; end \
  if ((c) !== 1'b1) begin num_errors++; print_verdict(); end end
module tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic halt_exec = 1'b0;
  logic timer_clear = 1'b0;
  logic timer_enable = 1'b0;
  logic port_wr = 1'b0;
  logic [3:0] mode_value = 4'h0;
  logic [7:0] acc_in = 8'h00;
  logic [7:0] level_req = 8'h00;
  logic reset_req = 1'b0;
  logic [7:0] pins, acc_out, port_dir, port_data, pend;
  logic reset_pin_n, acc_valid, clk_en, expiry, halted;
  logic pc_load, timer_rst, pin_irq;
  int num_errors = 0;
  int checks_done = 0;
  int n;
  int irq_count = 0;

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (pin_irq === 1'b1) irq_count++;

  pdw_pin_model pdw_pin_model_inst (.clk(core_clk), .level_req(level_req),
    .reset_req(reset_req), .pins(pins), .reset_pin_n(reset_pin_n));

  pdw_top #(.TIMER_CYCLES(20)) pdw_top_inst (.CORE_CLK(core_clk),
    .RST(rst), .EXTERNAL_RESET_PIN_N(reset_pin_n), .HALT_EXEC(halt_exec),
    .TIMER_CLEAR(timer_clear), .TIMER_ENABLE(timer_enable),
    .PORT_WR(port_wr),
    .MODE_VALUE(mode_value), .ACC_IN(acc_in), .ACC_OUT(acc_out),
    .ACC_OUT_VALID(acc_valid), .PORT_DIR(port_dir), .PORT_DATA(port_data),
    .SECOND_PORT_PINS(pins), .CORE_CLK_EN(clk_en), .EXPIRY_FLAG(expiry),
    .HALTED_FLAG(halted), .PC_LOAD(pc_load), .TIMER_RESET(timer_rst),
    .PIN_IRQ(pin_irq), .RESUME_PENDING(pend));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic port_wr_t(input logic [3:0] m, input logic [7:0] v);
    @(posedge core_clk);
    port_wr <= 1'b1;
    mode_value <= m;
    acc_in <= v;
    @(posedge core_clk);
    port_wr <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic set_pins(input logic [7:0] v, input int quiet);
    @(posedge core_clk);
    level_req <= v;
    repeat (quiet) @(negedge core_clk);
  endtask

  task automatic halt_t;
    @(posedge core_clk);
    halt_exec <= 1'b1;
    @(posedge core_clk);
    halt_exec <= 1'b0;
    @(negedge core_clk);
    `CHK(clk_en, 1'b0)
    `CHK(halted, 1'b0)
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset;
    `CHK(clk_en, 1'b1)
    `CHK(port_dir, 8'hFF)
    set_pins(8'h01, 8);
    `CHK(pend[0], 1'b0)
    set_pins(8'h00, 8);
    `CHK(pend[0], 1'b1)
    `CHK(irq_count, 0)
    $display("test_reset done");
  endtask

  task automatic test_config;
    port_wr_t(pdw_pkg::MODE_DIR, 8'h0F);
    `CHK(port_dir, 8'h0F)
    port_wr_t(4'h3, 8'h5A);
    `CHK(port_data, 8'h5A)
    `CHK(acc_valid, 1'b0)
    port_wr_t(pdw_pkg::MODE_EDGE, 8'h01);
    port_wr_t(pdw_pkg::MODE_PEND, 8'h00);
    `CHK(acc_valid, 1'b1)
    `CHK(acc_out, 8'h01)
    `CHK(pend, 8'h00)
    port_wr_t(pdw_pkg::MODE_EN, 8'hFC);
    $display("test_config done");
  endtask

  task automatic test_run;
    set_pins(8'h02, 0);
    `WAITF(pin_irq)
    `CHK(pend, 8'h02)
    set_pins(8'h06, 8);
    `CHK(pend, 8'h06)
    `CHK(irq_count, 1)
    port_wr_t(pdw_pkg::MODE_PEND, 8'h00);
    `CHK(acc_out, 8'h06)
    $display("test_run done");
  endtask

  task automatic test_pin_wake;
    halt_t();
    `CHK(expiry, 1'b1)
    port_wr_t(pdw_pkg::MODE_DIR, 8'hAA);
    `CHK(port_dir, 8'h0F)
    set_pins(8'h0E, 8);
    `CHK(clk_en, 1'b0)
    set_pins(8'h0F, 8);
    `CHK(clk_en, 1'b0)
    set_pins(8'h0E, 0);
    `WAITF(pc_load)
    `CHK(clk_en, 1'b1)
    `CHK(pend, 8'h09)
    $display("test_pin_wake done");
  endtask

  task automatic test_timer;
    @(posedge core_clk);
    timer_enable <= 1'b1;
    halt_t();
    `WAITF(timer_rst)
    `CHK(expiry, 1'b0)
    `CHK(pc_load, 1'b1)
    halt_t();
    `CHK(expiry, 1'b1)
    @(posedge core_clk);
    reset_req <= 1'b1;
    `WAITF(pc_load)
    `CHK(clk_en, 1'b1)
    `CHK(timer_rst, 1'b0)
    `CHK(port_dir, 8'hFF)
    @(posedge core_clk);
    reset_req <= 1'b0;
    timer_enable <= 1'b0;
    timer_clear <= 1'b1;
    @(posedge core_clk);
    timer_clear <= 1'b0;
    @(negedge core_clk);
    `CHK(halted, 1'b1)
    `CHK(expiry, 1'b1)
    $display("test_timer done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    test_reset();
    test_config();
    test_run();
    test_pin_wake();
    test_timer();
    print_verdict();
  end
endmodule
